// *** rtl/spm_map_access.sv ***
// protection map erase, program and read over the serial link
//
// Operation
// RULE1: eight-byte map, byte n selects protection of sector n.
// RULE2: map is erased before reprogramming; programming only clears bits.
// RULE3: byte FFH protects, 00H unprotects; other values treated unprotected.
// RULE4: sector zero bits 7:6 and 5:4 govern its two parts; 3:0 ignored.
// RULE5: every map byte reads 00H after reset.
// RULE6: opcode 3DH 2AH 7FH CFH decodes as map erase.
// RULE7: chip select release after erase opcode starts timed erase, busy shown.
// RULE8: erase sets every map byte to FFH.
// RULE9: erase accepted whether global protection is on or off.
// RULE10: opcode 3DH 2AH 7FH FCH followed by map data bytes.
// RULE11: program data bytes land in sector order from sector zero.
// RULE12: chip select release after data starts timed program, busy shown.
// RULE13: host supplies all data bytes before releasing chip select.
// RULE14: data beyond eight bytes wraps the pointer to byte zero.
// RULE15: program accepted whether global protection is on or off.
// RULE16: program uses the internal data buffer, overwriting its contents.
// RULE17: opcode 32H plus three dummy bytes, then map bytes from sector zero.
// RULE18: clocks past the last map byte give undefined output.
// RULE19: chip select release puts serial output in high impedance.
// RULE20: write protect pin asserted refuses map erase and program.
// RULE21: marked sectors blocked only while global protection is enabled.
// RULE22: input sampled on rising clock, output driven after falling clock.
`timescale 1ns/1ns
`default_nettype none

module spm_map_access
    import spm_pkg::*;
#(
    parameter int ERASE_CYCLES = MAP_ERASE_CYCLES,
    parameter int PROGRAM_CYCLES = MAP_PROGRAM_CYCLES
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic linkClk,
    input wire logic csN,
    input wire logic si,
    output logic so,
    output logic soEnN,
    input wire logic wpN,
    input wire logic protectCmdEn,
    output logic busy,
    output logic [BLOCK_W-1:0] sectorBlock,
    output logic bufClobbered,
    output logic mapWriteRefused
);

    // ****************************************
    // link side state
    // ****************************************
    // the link clock stops between frames, so the frame's own chip select
    // clears the per-frame state instead of a trailing clock edge
    logic linkRst;
    spm_link_s lnk_reg;
    spm_link_s lnk_next;
    spm_hold_s hold_reg;
    spm_hold_s hold_next;
    spm_so_s so_reg;
    spm_so_s so_next;
    spm_sys_s sys_reg;
    spm_sys_s sys_next;
    logic [31:0] shifted;
    logic [BIT_CNT_W-1:0] dataIdx;
    logic [5:0] flatIdx;
    logic protOn;

    assign linkRst = ~resetn | csN;

    always_comb begin
        lnk_next = lnk_reg;
        hold_next = hold_reg;
        shifted = {lnk_reg.shiftReg[30:0], si}; // RULE22
        lnk_next.shiftReg = shifted;
        if (lnk_reg.bitCnt != BIT_CNT_MAX) begin
            lnk_next.bitCnt = lnk_reg.bitCnt + 10'h001;
        end
        if (lnk_reg.bitCnt == OPCODE_LAST_BIT) begin
            hold_next.cmd = CMD_NONE;
            if (shifted == OP_MAP_ERASE) begin // RULE6
                hold_next.cmd = CMD_ERASE;
                hold_next.cmdToggle = ~hold_reg.cmdToggle;
            end else if (shifted == OP_MAP_PROGRAM) begin // RULE10
                hold_next.cmd = CMD_PROGRAM;
                hold_next.cmdToggle = ~hold_reg.cmdToggle;
                lnk_next.programming = 1'b1;
            end else if (shifted[31:24] == OP_MAP_READ) begin // RULE17
                lnk_next.reading = 1'b1;
            end
        end else if (lnk_reg.bitCnt >= DATA_FIRST_BIT) begin
            // erase is only valid when chip select rises right after the opcode
            if (hold_reg.cmd == CMD_ERASE) begin // RULE7
                hold_next.cmd = CMD_NONE;
            end
            if (lnk_reg.programming && lnk_reg.bitCnt[2:0] == 3'h7) begin
                hold_next.dataBuf[lnk_reg.wrPtr] = shifted[7:0]; // RULE11
                lnk_next.wrPtr = lnk_reg.wrPtr + 3'h1; // RULE14
            end
        end
    end

    always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
            lnk_reg <= '0;
        end else begin
            lnk_reg <= lnk_next;
        end
    end

    // command word and data outlive the frame; the system side reads them
    // only after chip select has risen, when they no longer move
    always_ff @(posedge linkClk or negedge resetn) begin
        if (!resetn) begin
            hold_reg <= '0;
        end else begin
            hold_reg <= hold_next;
        end
    end

    // ****************************************
    // serial output
    // ****************************************
    // map is sampled directly; reading during busy may return a mix
    always_comb begin
        so_next = so_reg;
        dataIdx = lnk_reg.bitCnt - DATA_FIRST_BIT;
        flatIdx = {dataIdx[5:3], ~dataIdx[2:0]};
        if (lnk_reg.reading && lnk_reg.bitCnt >= DATA_FIRST_BIT) begin
            so_next.soEnN = 1'b0;
            if (dataIdx < READ_DATA_BITS) begin
                so_next.soBit = sys_reg.map[flatIdx[5:3]][flatIdx[2:0]]; // RULE17
            end else begin
                so_next.soBit = 1'b0; // RULE18
            end
        end
    end

    always_ff @(negedge linkClk or posedge linkRst) begin
        if (linkRst) begin
            so_reg <= '{soBit: 1'b0, soEnN: 1'b1}; // RULE19
        end else begin
            so_reg <= so_next; // RULE22
        end
    end

    assign so = so_reg.soBit;
    assign soEnN = so_reg.soEnN;

    // ****************************************
    // system side
    // ****************************************
    always_comb begin
        sys_next = sys_reg;
        sys_next.cs1 = csN;
        sys_next.cs2 = sys_reg.cs1;
        sys_next.cs3 = sys_reg.cs2;
        sys_next.tg1 = hold_reg.cmdToggle;
        sys_next.tg2 = sys_reg.tg1;
        sys_next.wp1 = wpN;
        sys_next.wp2 = sys_reg.wp1;
        sys_next.clobbered = 1'b0;
        sys_next.refused = 1'b0;
        if (sys_reg.cs2 && !sys_reg.cs3) begin
            sys_next.tgSeen = sys_reg.tg2;
        end
        case (sys_reg.state)
            ST_IDLE: begin
                // a command arriving while busy is dropped, like any busy flash
                if (sys_reg.cs2 && !sys_reg.cs3 && sys_reg.tg2 != sys_reg.tgSeen) begin
                    if (hold_reg.cmd != CMD_NONE && !sys_reg.wp2) begin
                        sys_next.refused = 1'b1; // RULE20
                    end else if (hold_reg.cmd == CMD_ERASE) begin
                        sys_next.state = ST_ERASE; // RULE7 RULE9
                        sys_next.timer = 32'(ERASE_CYCLES - 1);
                    end else if (hold_reg.cmd == CMD_PROGRAM) begin
                        sys_next.state = ST_PROGRAM; // RULE12 RULE15
                        sys_next.timer = 32'(PROGRAM_CYCLES - 1);
                        sys_next.sram = hold_reg.dataBuf; // RULE16
                        sys_next.clobbered = 1'b1;
                    end
                end
            end
            ST_ERASE: begin
                if (sys_reg.timer == 32'h00000000) begin
                    sys_next.map = {MAP_BYTES{BYTE_PROTECTED}}; // RULE8
                    sys_next.state = ST_IDLE;
                end else begin
                    sys_next.timer = sys_reg.timer - 32'h00000001;
                end
            end
            ST_PROGRAM: begin
                if (sys_reg.timer == 32'h00000000) begin
                    // flash cells only go from one to zero
                    sys_next.map = sys_reg.map & sys_reg.sram; // RULE2 RULE1
                    sys_next.state = ST_IDLE;
                end else begin
                    sys_next.timer = sys_reg.timer - 32'h00000001;
                end
            end
            default: begin
                sys_next.state = ST_IDLE;
            end
        endcase
        sys_next.busy = (sys_next.state != ST_IDLE); // RULE7 RULE12
        protOn = protectCmdEn | ~sys_reg.wp2;
        sys_next.block[0] = protOn &
            (sys_reg.map[0][ZERO_LOW_HI:ZERO_LOW_LO] == PART_PROTECTED); // RULE4
        sys_next.block[1] = protOn &
            (sys_reg.map[0][ZERO_HIGH_HI:ZERO_HIGH_LO] == PART_PROTECTED); // RULE4
        for (int k = 1; k < MAP_BYTES; k++) begin
            sys_next.block[k + 1] = protOn & (sys_reg.map[k] == BYTE_PROTECTED); // RULE3 RULE21
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sys_reg <= '{cs1: 1'b1, cs2: 1'b1, cs3: 1'b1, wp1: 1'b1, wp2: 1'b1,
                         state: ST_IDLE, map: {MAP_BYTES{BYTE_RESET}}, default: '0}; // RULE5
        end else begin
            sys_reg <= sys_next;
        end
    end

    assign busy = sys_reg.busy;
    assign sectorBlock = sys_reg.block;
    assign bufClobbered = sys_reg.clobbered;
    assign mapWriteRefused = sys_reg.refused;

    // ****************************************
    // checks
    // ****************************************
    erase_fill_a: assert property ( // RULE8
        @(posedge sys_clk) disable iff (!resetn)
        (sys_reg.state == ST_ERASE && sys_reg.timer == 32'h00000000)
            |=> (sys_reg.map == {MAP_BYTES{BYTE_PROTECTED}}) && !sys_reg.busy)
        else $error("erase did not fill map");

    program_and_a: assert property ( // RULE2
        @(posedge sys_clk) disable iff (!resetn)
        (sys_reg.state == ST_PROGRAM && sys_reg.timer == 32'h00000000)
            |=> sys_reg.map == ($past(sys_reg.map) & $past(sys_reg.sram)))
        else $error("program result wrong");

    wp_refuse_a: assert property ( // RULE20
        @(posedge sys_clk) disable iff (!resetn)
        $rose(sys_reg.refused) |-> !sys_reg.busy && $stable(sys_reg.map))
        else $error("refused command went busy");

    busy_track_a: assert property ( // RULE7
        @(posedge sys_clk) disable iff (!resetn)
        (sys_reg.state != ST_IDLE) |-> sys_reg.busy)
        else $error("busy low during cycle");

    map_hold_a: assert property ( // RULE12
        @(posedge sys_clk) disable iff (!resetn)
        (sys_reg.state == ST_PROGRAM && sys_reg.timer != 32'h00000000)
            |=> $stable(sys_reg.map) && sys_reg.busy)
        else $error("map changed before program ended");

    buf_clobber_a: assert property ( // RULE16
        @(posedge sys_clk) disable iff (!resetn)
        $rose(sys_reg.state == ST_PROGRAM) |-> sys_reg.clobbered ##1 !sys_reg.clobbered)
        else $error("buffer overwrite not flagged");

    prot_gate_a: assert property ( // RULE21
        @(posedge sys_clk) disable iff (!resetn)
        (!protectCmdEn && sys_reg.wp2) |=> (sys_reg.block == '0))
        else $error("sector blocked with protection off");

    zero_split_a: assert property ( // RULE4
        @(posedge sys_clk) disable iff (!resetn)
        (protectCmdEn && sys_reg.map[0] == 8'hC0) |=> (sys_reg.block[1:0] == 2'h1))
        else $error("sector zero parts decoded wrong");

    ptr_wrap_a: assert property ( // RULE14
        @(posedge linkClk) disable iff (linkRst)
        (lnk_reg.programming && lnk_reg.bitCnt >= DATA_FIRST_BIT &&
         lnk_reg.bitCnt[2:0] == 3'h7 && lnk_reg.wrPtr == 3'h7) |=> (lnk_reg.wrPtr == 3'h0))
        else $error("data pointer did not wrap");

    erase_decode_a: assert property ( // RULE6
        @(posedge linkClk) disable iff (linkRst)
        (lnk_reg.bitCnt == OPCODE_LAST_BIT && shifted == OP_MAP_ERASE)
            |-> (hold_next.cmd == CMD_ERASE) && (hold_next.cmdToggle != hold_reg.cmdToggle))
        else $error("erase opcode not decoded");

    prog_decode_a: assert property ( // RULE10
        @(posedge linkClk) disable iff (linkRst)
        (lnk_reg.bitCnt == OPCODE_LAST_BIT && shifted == OP_MAP_PROGRAM)
            |=> (hold_reg.cmd == CMD_PROGRAM) && lnk_reg.programming)
        else $error("program opcode not decoded");

    data_slot_a: assert property ( // RULE11
        @(posedge linkClk) disable iff (linkRst)
        (lnk_reg.programming && lnk_reg.bitCnt >= DATA_FIRST_BIT && lnk_reg.bitCnt[2:0] == 3'h7)
            |-> (lnk_reg.wrPtr == 3'(lnk_reg.bitCnt[5:3] + 3'h4)))
        else $error("data byte slot out of order");

    data_store_a: assert property ( // RULE11
        @(posedge linkClk) disable iff (linkRst)
        (lnk_reg.programming && lnk_reg.bitCnt >= DATA_FIRST_BIT && lnk_reg.bitCnt[2:0] == 3'h7)
            |=> (hold_reg.dataBuf[$past(lnk_reg.wrPtr)] == $past(shifted[7:0])))
        else $error("data byte not stored");

    read_decode_a: assert property ( // RULE17
        @(posedge linkClk) disable iff (linkRst)
        (lnk_reg.bitCnt == OPCODE_LAST_BIT && shifted[31:24] == OP_MAP_READ) |=> lnk_reg.reading)
        else $error("read opcode not decoded");

    so_drive_a: assert property ( // RULE17
        @(posedge linkClk) disable iff (linkRst)
        (lnk_reg.reading && lnk_reg.bitCnt >= DATA_FIRST_BIT) |-> !so_reg.soEnN)
        else $error("output not driven during read");

    so_release_a: assert property ( // RULE19
        @(posedge sys_clk) disable iff (!resetn)
        linkRst |-> so_reg.soEnN)
        else $error("output driven without chip select");

    erase_start_a: assert property ( // RULE7
        @(posedge sys_clk) disable iff (!resetn)
        (sys_reg.state == ST_IDLE && sys_next.state == ST_ERASE)
            |=> sys_reg.busy && (sys_reg.timer == 32'(ERASE_CYCLES - 1)))
        else $error("erase did not start busy");

    prog_start_a: assert property ( // RULE12
        @(posedge sys_clk) disable iff (!resetn)
        (sys_reg.state == ST_IDLE && sys_next.state == ST_PROGRAM)
            |=> sys_reg.busy && (sys_reg.timer == 32'(PROGRAM_CYCLES - 1)))
        else $error("program did not start busy");

    wp_only_a: assert property ( // RULE20
        @(posedge sys_clk) disable iff (!resetn)
        $rose(sys_reg.refused) |-> !$past(sys_reg.wp2))
        else $error("refused without write protect");

    zero_high_a: assert property ( // RULE4
        @(posedge sys_clk) disable iff (!resetn)
        (protectCmdEn && sys_reg.map[0][7:4] == 4'h3) |=> (sys_reg.block[1:0] == 2'h2))
        else $error("sector zero high part decoded wrong");

    sector_mark_a: assert property ( // RULE21
        @(posedge sys_clk) disable iff (!resetn)
        (!sys_reg.wp2 && sys_reg.map[2] == BYTE_PROTECTED) |=> sys_reg.block[3])
        else $error("pin protection not applied");

    sector_free_a: assert property ( // RULE3
        @(posedge sys_clk) disable iff (!resetn)
        (sys_reg.map[1] == BYTE_RESET) |=> !sys_reg.block[2])
        else $error("unprotected sector blocked");

    busy_idle_a: assert property ( // RULE12
        @(posedge sys_clk) disable iff (!resetn)
        (sys_reg.state == ST_IDLE) |-> !sys_reg.busy)
        else $error("busy high while idle");

endmodule : spm_map_access

`default_nettype wire

// *** rtl/spm_pkg.sv ***
// shared constants and types for the protection map access block
package spm_pkg;

    // ****************************************
    // map geometry
    // ****************************************
    localparam int MAP_BYTES = 8;
    localparam int PTR_W = 3;
    localparam int BIT_CNT_W = 10;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_MAX = 10'h3FF;
    localparam logic [BIT_CNT_W-1:0] OPCODE_LAST_BIT = 10'h01F;
    localparam logic [BIT_CNT_W-1:0] DATA_FIRST_BIT = 10'h020;
    localparam logic [BIT_CNT_W-1:0] READ_DATA_BITS = 10'h040;
    localparam logic [7:0] BYTE_PROTECTED = 8'hFF;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] PART_PROTECTED = 2'h3;
    localparam int ZERO_LOW_HI = 7;
    localparam int ZERO_LOW_LO = 6;
    localparam int ZERO_HIGH_HI = 5;
    localparam int ZERO_HIGH_LO = 4;
    localparam int BLOCK_W = 9;

    // ****************************************
    // opcodes
    // ****************************************
    localparam logic [31:0] OP_MAP_ERASE = 32'h3D2A7FCF;
    localparam logic [31:0] OP_MAP_PROGRAM = 32'h3D2A7FFC;
    localparam logic [7:0] OP_MAP_READ = 8'h32;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 125;
    localparam int MAP_ERASE_TIME_US = 50;
    localparam int MAP_PROGRAM_TIME_US = 50;
    localparam int MAP_ERASE_CYCLES = MAP_ERASE_TIME_US * CLK_MHZ;
    localparam int MAP_PROGRAM_CYCLES = MAP_PROGRAM_TIME_US * CLK_MHZ;

    // ****************************************
    // types
    // ****************************************
    typedef logic [MAP_BYTES-1:0][7:0] spm_map_t;

    typedef enum logic [1:0] {CMD_NONE, CMD_ERASE, CMD_PROGRAM} spm_cmd_e;

    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROGRAM} spm_state_e;

    typedef struct packed {
        logic [31:0] shiftReg;
        logic [BIT_CNT_W-1:0] bitCnt;
        logic [PTR_W-1:0] wrPtr;
        logic reading;
        logic programming;
    } spm_link_s;

    typedef struct packed {
        spm_cmd_e cmd;
        logic cmdToggle;
        spm_map_t dataBuf;
    } spm_hold_s;

    typedef struct packed {
        logic soBit;
        logic soEnN;
    } spm_so_s;

    typedef struct packed {
        logic cs1;
        logic cs2;
        logic cs3;
        logic tg1;
        logic tg2;
        logic tgSeen;
        logic wp1;
        logic wp2;
        spm_state_e state;
        logic [31:0] timer;
        spm_map_t map;
        spm_map_t sram;
        logic busy;
        logic [BLOCK_W-1:0] block;
        logic clobbered;
        logic refused;
    } spm_sys_s;

endpackage : spm_pkg

// *** testbench/spm_host_model.sv ***
// host serial controller model that drives the protection map link
`timescale 1ns/1ns
`default_nettype none

module spm_host_model (
    output logic linkClk,
    output logic csN,
    output logic si,
    input wire logic so
);

    // ****************************************
    // idle levels
    // ****************************************
    // clock stands still low between frames (mode 0)
    initial begin
        linkClk = 1'b0;
        csN = 1'b1;
        si = 1'b1;
    end

    // ****************************************
    // one frame
    // ****************************************
    // tx is left aligned, msb first; rx collects the bits sampled after tx is spent
    task automatic frame(input logic [103:0] tx, input int nTx, input int nRx,
                         output logic [71:0] rx);
        rx = '0;
        csN = 1'b0;
        for (int i = 0; i < nTx + nRx; i++) begin
            // past the payload the line carries no meaning, so it toggles
            si = (i < nTx) ? tx[103 - i] : ~si;
            #40 linkClk = 1'b1;
            if (i >= nTx) begin
                rx = {rx[70:0], so};
            end
            #40 linkClk = 1'b0;
        end
        #40 csN = 1'b1;
        si = ~si;
    endtask : frame

endmodule : spm_host_model

`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the protection map access block
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import spm_pkg::*;

    localparam int CYC = 20;
    localparam logic [63:0] PROG_MAP = 64'h3F00FF00FF00FF00;

    logic sys_clk;
    logic resetn;
    logic wpN;
    logic protectCmdEn;
    logic linkClk;
    logic csN;
    logic si;
    logic so;
    logic soEnN;
    logic busy;
    logic bufClobbered;
    logic mapWriteRefused;
    logic [BLOCK_W-1:0] sectorBlock;
    logic [71:0] rx;
    int fails;
    int compares;
    int busyCnt;
    int clobCnt;
    int refCnt;

    spm_map_access #(.ERASE_CYCLES(CYC), .PROGRAM_CYCLES(CYC)) spm_map_access_i (
        .sys_clk(sys_clk), .resetn(resetn), .linkClk(linkClk), .csN(csN), .si(si),
        .so(so), .soEnN(soEnN), .wpN(wpN), .protectCmdEn(protectCmdEn), .busy(busy),
        .sectorBlock(sectorBlock), .bufClobbered(bufClobbered),
        .mapWriteRefused(mapWriteRefused)
    );

    spm_host_model spm_host_model_i (.linkClk(linkClk), .csN(csN), .si(si), .so(so));

    // ****************************************
    // helpers
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check(input string name, input logic [71:0] seen, input logic [71:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic set_pins(input logic wp, input logic pe, input int settle);
        @(posedge sys_clk);
        #1;
        wpN = wp;
        protectCmdEn = pe;
        repeat (settle) @(posedge sys_clk);
        #1;
    endtask : set_pins

    // counts busy cycles and pulses until busy falls, or a quiet spell shows nothing started
    task automatic observe();
        bit seen;
        seen = 1'b0;
        busyCnt = 0;
        clobCnt = 0;
        refCnt = 0;
        for (int i = 0; i < 200; i++) begin
            @(posedge sys_clk);
            #1;
            busyCnt += (busy === 1'b1);
            clobCnt += (bufClobbered === 1'b1);
            refCnt += (mapWriteRefused === 1'b1);
            if (busy === 1'b1) begin
                seen = 1'b1;
            end
            if ((seen && busy === 1'b0) || (!seen && i == 40)) begin
                return;
            end
        end
        fails++;
        wrap_up();
    endtask : observe

    task automatic read_map(input logic [63:0] exp);
        spm_host_model_i.frame({OP_MAP_READ, 96'h0}, 32, 64, rx);
        check("mapRead", rx[63:0], {8'h00, exp});
        #1;
        check("soEnNIdle", {71'h0, soEnN}, 72'h1);
    endtask : read_map

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        read_map(64'h0);
        check("busyIdle", {71'h0, busy}, 72'h0);
        check("blockReset", {63'h0, sectorBlock}, 72'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_erase();
        set_pins(1'b1, 1'b1, 1);
        spm_host_model_i.frame({OP_MAP_ERASE, 72'h0}, 32, 0, rx);
        observe();
        check("eraseBusy", 72'(busyCnt), 72'(CYC));
        check("eraseRefused", 72'(refCnt), 72'h0);
        read_map(64'hFFFFFFFFFFFFFFFF);
        check("blockErased", {63'h0, sectorBlock}, 72'h1FF);
        $display("test erase done");
    endtask : t_erase

    task automatic t_program();
        set_pins(1'b1, 1'b0, 1);
        // nine bytes: the last wraps onto sector zero with ignored low bits set
        spm_host_model_i.frame({OP_MAP_PROGRAM, 72'hFF00FF00FF00FF003F}, 104, 0, rx);
        observe();
        check("progBusy", 72'(busyCnt), 72'(CYC));
        check("progClobber", 72'(clobCnt), 72'h1);
        read_map(PROG_MAP);
        check("blockOff", {63'h0, sectorBlock}, 72'h0);
        set_pins(1'b1, 1'b1, 3);
        check("blockCmd", {63'h0, sectorBlock}, 72'h0AA);
        set_pins(1'b0, 1'b0, 5);
        check("blockPin", {63'h0, sectorBlock}, 72'h0AA);
        $display("test program done");
    endtask : t_program

    task automatic t_wp_refuse();
        logic [103:0] cmds [2];
        int lens [2];
        cmds[0] = {OP_MAP_ERASE, 72'h0};
        cmds[1] = {OP_MAP_PROGRAM, 72'h0};
        lens[0] = 32;
        lens[1] = 96;
        for (int k = 0; k < 2; k++) begin
            spm_host_model_i.frame(cmds[k], lens[k], 0, rx);
            observe();
            check("wpRefused", 72'(refCnt), 72'h1);
            check("wpNoBusy", 72'(busyCnt), 72'h0);
        end
        read_map(PROG_MAP);
        set_pins(1'b1, 1'b0, 1);
        $display("test write protect done");
    endtask : t_wp_refuse

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        resetn = 1'b0;
        wpN = 1'b1;
        protectCmdEn = 1'b0;
        fails = 0;
        compares = 0;
        repeat (10) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
        t_reset();
        t_erase();
        t_program();
        t_wp_refuse();
        wrap_up();
    end

    // a hang counts as a mismatch
    initial begin
        #500000;
        fails++;
        wrap_up();
    end

endmodule : testbench

`default_nettype wire
